/* verilog/qsg_status.sv */
// Top: questionable status groups for error-rate test and calibration
//
// Operation
// - Error-rate cond bit 0 set while no test clock for over three seconds; code sets it only while error_rate_test_active is high.
// - Condition registers track live state; reading does not latch or clear.
// - Reads return plain unsigned value, the sum of set bit weights.
// - Event bits set only by filtered condition transitions, never by level.
// - Event bits stay latched until read; read returns then clears them.
// - Condition 1 to 0 with fall filter bit set sets event bit.
// - Condition 0 to 1 with rise filter bit set sets event bit.
// - Questionable bit 12 high when any error-rate event and enable overlap.
// - Questionable bit 8 high when any calibration event and enable overlap.
// - Calibration cond bit 0 set while DC FM or phase zero cal failed.
// - Preset command restores all filters and enables at once.
//
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ns
module qsg_status
  import qsg_pkg::*;
#(
  parameter int W = 16,
  parameter longint NOCLK_CYCLES = QSG_NOCLK_CYCLES
) (
  input wire logic sys_clk, // System clock, 50 MHz
  input wire logic nrst, // Synchronous reset, active low
  input wire logic [QSG_AW-1:0] addr, // Register index
  input wire logic [QSG_DW-1:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [QSG_DW-1:0] rdata, // Read data, cycle after rd
  input wire logic error_rate_test_active, // Measurement running (pin)
  input wire logic error_rate_test_clk, // Test data clock (pin)
  input wire logic cal_fail_dc_freq_mod, // FM zero cal failed (pin)
  input wire logic cal_fail_dc_phase_mod, // Phase zero cal failed (pin)
  input wire logic [W-1:0] ert_cond_ext, // Other error-rate condition bits
  input wire logic [W-1:0] cal_cond_ext, // Other calibration condition bits
  output logic ques_ert_summary, // Questionable bit 12
  output logic ques_cal_summary, // Questionable bit 8
  output logic irq // Level interrupt
);
  initial begin
    if (W < 1 || W > QSG_DW) $error("qsg_status: W out of range");
    if (NOCLK_CYCLES < 2) $error("qsg_status: NOCLK_CYCLES too small");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      sync1_r <= {cal_fail_dc_phase_mod, cal_fail_dc_freq_mod,
                  error_rate_test_clk, error_rate_test_active};
      sync2_r <= sync1_r;
    end
  end
  wire meas_on = sync2_r[0];
  wire tclk_s = sync2_r[1];
  wire cal_fail = sync2_r[2] | sync2_r[3];

  // ----------------------------------------------------------------
  // Missing-clock timer
  // ----------------------------------------------------------------
  localparam int CW = $clog2(NOCLK_CYCLES + 1);
  localparam logic [CW-1:0] CMAX = CW'(NOCLK_CYCLES);
  logic tclk_d_r;
  logic [CW-1:0] idle_cnt_r;
  logic [CW-1:0] idle_cnt_nxt;
  logic noclk_r;
  wire tclk_edge = tclk_s & ~tclk_d_r;
  always_comb begin
    idle_cnt_nxt = idle_cnt_r;
    if (!meas_on || tclk_edge) begin
      idle_cnt_nxt = '0;
    end else if (idle_cnt_r != CMAX) begin
      idle_cnt_nxt = idle_cnt_r + CW'(1);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      tclk_d_r <= 1'b0;
      idle_cnt_r <= '0;
      noclk_r <= 1'b0;
    end else begin
      tclk_d_r <= tclk_s;
      idle_cnt_r <= idle_cnt_nxt;
      noclk_r <= meas_on && !tclk_edge && (idle_cnt_r == CMAX);
    end
  end

  // ----------------------------------------------------------------
  // Live condition vectors
  // ----------------------------------------------------------------
  logic [W-1:0] ert_cond;
  logic [W-1:0] cal_cond;
  always_comb begin
    ert_cond = ert_cond_ext;
    ert_cond[QSG_ERT_NOCLK_BIT] = noclk_r;
    cal_cond = cal_cond_ext;
    cal_cond[QSG_CAL_ZERO_BIT] = cal_fail;
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire wr_ert_en = wr && addr == QSG_ERT_ENABLE;
  wire wr_ert_rise = wr && addr == QSG_ERT_RISE;
  wire wr_ert_fall = wr && addr == QSG_ERT_FALL;
  wire wr_cal_en = wr && addr == QSG_CAL_ENABLE;
  wire wr_cal_rise = wr && addr == QSG_CAL_RISE;
  wire wr_cal_fall = wr && addr == QSG_CAL_FALL;
  wire wr_preset = wr && addr == QSG_PRESET;
  wire wr_irq_stat = wr && addr == QSG_IRQ_STATUS;
  wire wr_irq_mask = wr && addr == QSG_IRQ_MASK;
  wire rd_ert_event = rd && addr == QSG_ERT_EVENT;
  wire rd_cal_event = rd && addr == QSG_CAL_EVENT;

  // ----------------------------------------------------------------
  // Filter and enable registers
  // ----------------------------------------------------------------
  localparam logic [W-1:0] RISE_P = QSG_RISE_PRESET[W-1:0];
  localparam logic [W-1:0] FALL_P = QSG_FALL_PRESET[W-1:0];
  localparam logic [W-1:0] EN_P = QSG_ENABLE_PRESET[W-1:0];
  logic [W-1:0] ert_rise_r;
  logic [W-1:0] ert_fall_r;
  logic [W-1:0] ert_en_r;
  logic [W-1:0] cal_rise_r;
  logic [W-1:0] cal_fall_r;
  logic [W-1:0] cal_en_r;
  wire [W-1:0] wmask = wdata[W-1:0];
  always_ff @(posedge sys_clk) begin
    if (!nrst || wr_preset) begin
      ert_rise_r <= RISE_P;
      ert_fall_r <= FALL_P;
      ert_en_r <= EN_P;
      cal_rise_r <= RISE_P;
      cal_fall_r <= FALL_P;
      cal_en_r <= EN_P;
    end else begin
      if (wr_ert_rise) ert_rise_r <= wmask;
      if (wr_ert_fall) ert_fall_r <= wmask;
      if (wr_ert_en) ert_en_r <= wmask;
      if (wr_cal_rise) cal_rise_r <= wmask;
      if (wr_cal_fall) cal_fall_r <= wmask;
      if (wr_cal_en) cal_en_r <= wmask;
    end
  end

  // ----------------------------------------------------------------
  // Group instances
  // ----------------------------------------------------------------
  qsg_group_if #(.W(W)) ert_if ();
  qsg_group_if #(.W(W)) cal_if ();
  assign ert_if.cond = ert_cond;
  assign ert_if.rise_filter = ert_rise_r;
  assign ert_if.fall_filter = ert_fall_r;
  assign ert_if.enable = ert_en_r;
  assign ert_if.event_clr = rd_ert_event;
  assign cal_if.cond = cal_cond;
  assign cal_if.rise_filter = cal_rise_r;
  assign cal_if.fall_filter = cal_fall_r;
  assign cal_if.enable = cal_en_r;
  assign cal_if.event_clr = rd_cal_event;

  qsg_group #(.W(W)) u_ert (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .g(ert_if)
  );
  qsg_group #(.W(W)) u_cal (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .g(cal_if)
  );

  assign ques_ert_summary = ert_if.summary;
  assign ques_cal_summary = cal_if.summary;

  // ----------------------------------------------------------------
  // Top-level questionable condition
  // ----------------------------------------------------------------
  logic [QSG_DW-1:0] ques_cond;
  always_comb begin
    ques_cond = '0;
    ques_cond[QSG_QUES_ERT_BIT] = ert_if.summary;
    ques_cond[QSG_QUES_CAL_BIT] = cal_if.summary;
  end

  // ----------------------------------------------------------------
  // Interrupt status and mask
  // ----------------------------------------------------------------
  logic [QSG_IRQ_W-1:0] irq_stat_r;
  logic [QSG_IRQ_W-1:0] irq_mask_r;
  wire [QSG_IRQ_W-1:0] irq_set = {cal_if.new_event, ert_if.new_event};
  wire [QSG_IRQ_W-1:0] irq_clr = wr_irq_stat ? wdata[QSG_IRQ_W-1:0] : '0;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq_stat_r <= '0;
      irq_mask_r <= '0;
    end else begin
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
      if (wr_irq_mask) irq_mask_r <= wdata[QSG_IRQ_W-1:0];
    end
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  function automatic logic [QSG_DW-1:0] ext(input logic [W-1:0] v);
    logic [QSG_DW-1:0] r;
    r = '0;
    r[W-1:0] = v;
    return r;
  endfunction : ext

  logic [QSG_DW-1:0] rd_val;
  always_comb begin
    case (addr)
      QSG_ERT_COND: rd_val = ext(ert_cond);
      QSG_ERT_EVENT: rd_val = ext(ert_if.event_bits);
      QSG_ERT_ENABLE: rd_val = ext(ert_en_r);
      QSG_ERT_RISE: rd_val = ext(ert_rise_r);
      QSG_ERT_FALL: rd_val = ext(ert_fall_r);
      QSG_CAL_COND: rd_val = ext(cal_cond);
      QSG_CAL_EVENT: rd_val = ext(cal_if.event_bits);
      QSG_CAL_ENABLE: rd_val = ext(cal_en_r);
      QSG_CAL_RISE: rd_val = ext(cal_rise_r);
      QSG_CAL_FALL: rd_val = ext(cal_fall_r);
      QSG_QUES_COND: rd_val = ques_cond;
      QSG_IRQ_STATUS: rd_val = {{(QSG_DW-QSG_IRQ_W){1'b0}}, irq_stat_r};
      QSG_IRQ_MASK: rd_val = {{(QSG_DW-QSG_IRQ_W){1'b0}}, irq_mask_r};
      default: rd_val = '0;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      rdata <= '0;
    end else begin
      rdata <= rd ? rd_val : '0;
    end
  end
endmodule : qsg_status

/* verilog/qsg_pkg.sv */
// Package: register map, field positions, reset values and timing for the status groups
package qsg_pkg;
  localparam int QSG_AW = 4;
  localparam int QSG_DW = 16;
  // Register offsets (word index)
  localparam logic [3:0] QSG_ERT_COND = 4'h0;
  localparam logic [3:0] QSG_ERT_EVENT = 4'h1;
  localparam logic [3:0] QSG_ERT_ENABLE = 4'h2;
  localparam logic [3:0] QSG_ERT_RISE = 4'h3;
  localparam logic [3:0] QSG_ERT_FALL = 4'h4;
  localparam logic [3:0] QSG_CAL_COND = 4'h5;
  localparam logic [3:0] QSG_CAL_EVENT = 4'h6;
  localparam logic [3:0] QSG_CAL_ENABLE = 4'h7;
  localparam logic [3:0] QSG_CAL_RISE = 4'h8;
  localparam logic [3:0] QSG_CAL_FALL = 4'h9;
  localparam logic [3:0] QSG_QUES_COND = 4'hA;
  localparam logic [3:0] QSG_PRESET = 4'hB;
  localparam logic [3:0] QSG_IRQ_STATUS = 4'hC;
  localparam logic [3:0] QSG_IRQ_MASK = 4'hD;
  // Field positions
  localparam int QSG_ERT_NOCLK_BIT = 0;
  localparam int QSG_CAL_ZERO_BIT = 0;
  localparam int QSG_QUES_ERT_BIT = 12;
  localparam int QSG_QUES_CAL_BIT = 8;
  localparam int QSG_IRQ_ERT_BIT = 0;
  localparam int QSG_IRQ_CAL_BIT = 1;
  localparam int QSG_IRQ_W = 2;
  // Preset / reset values
  localparam logic [15:0] QSG_RISE_PRESET = 16'hFFFF;
  localparam logic [15:0] QSG_FALL_PRESET = 16'h0000;
  localparam logic [15:0] QSG_ENABLE_PRESET = 16'h0000;
  // Timing: missing-clock timeout
  localparam longint QSG_CLK_HZ = 50000000;
  localparam longint QSG_NOCLK_TIME_S = 3;
  localparam longint QSG_NOCLK_CYCLES = QSG_NOCLK_TIME_S * QSG_CLK_HZ;
endpackage : qsg_pkg

/* verilog/qsg_group_if.sv */
// Interface: one status group's filter/event/enable signals
`timescale 1ns/1ns
interface qsg_group_if #(parameter int W = 16);
  logic [W-1:0] cond;
  logic [W-1:0] rise_filter;
  logic [W-1:0] fall_filter;
  logic [W-1:0] enable;
  logic event_clr;
  logic [W-1:0] event_bits;
  logic summary;
  logic new_event;
  modport ctl (output cond, output rise_filter, output fall_filter, output enable,
    output event_clr, input event_bits, input summary, input new_event);
  modport grp (input cond, input rise_filter, input fall_filter, input enable,
    input event_clr, output event_bits, output summary, output new_event);
endinterface : qsg_group_if

/* verilog/qsg_group.sv */
// One status group: edge filters feeding a latched event register
`timescale 1ns/1ns
module qsg_group
  import qsg_pkg::*;
#(
  parameter int W = 16
) (
  input wire logic sys_clk, // System clock
  input wire logic nrst, // Synchronous reset, active low
  qsg_group_if.grp g // Group signals
);
  initial begin
    if (W < 1 || W > QSG_DW) $error("qsg_group: W out of range");
  end
  logic [W-1:0] cond_d_r;
  logic [W-1:0] event_r;
  logic [W-1:0] event_nxt;
  wire [W-1:0] rise_hit = g.cond & ~cond_d_r & g.rise_filter;
  wire [W-1:0] fall_hit = ~g.cond & cond_d_r & g.fall_filter;
  wire [W-1:0] hits = rise_hit | fall_hit;
  // New hits win over the clear-on-read
  assign event_nxt = (g.event_clr ? '0 : event_r) | hits;
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cond_d_r <= '0;
      event_r <= '0;
    end else begin
      cond_d_r <= g.cond;
      event_r <= event_nxt;
    end
  end
  assign g.event_bits = event_r;
  assign g.summary = |(event_r & g.enable);
  assign g.new_event = |hits;
endmodule : qsg_group

/* verif/qsg_status_checker.sv */
// Checker: port-level properties of the status groups
`timescale 1ns/1ns
module qsg_status_checker
  import qsg_pkg::*;
#(parameter int W = 16, parameter longint NOCLK_CYCLES = QSG_NOCLK_CYCLES) (
  input wire logic sys_clk, // Clock
  input wire logic nrst, // Reset
  input wire logic [QSG_AW-1:0] addr, // Index
  input wire logic [QSG_DW-1:0] wdata, // Write data
  input wire logic wr, // Write
  input wire logic rd, // Read
  input wire logic [QSG_DW-1:0] rdata, // Read data
  input wire logic error_rate_test_active, // Active
  input wire logic error_rate_test_clk, // Test clock
  input wire logic cal_fail_dc_freq_mod, // FM fail
  input wire logic cal_fail_dc_phase_mod, // Phase fail
  input wire logic [W-1:0] ert_cond_ext, // Ext cond
  input wire logic [W-1:0] cal_cond_ext, // Ext cond
  input wire logic ques_ert_summary, // Bit 12
  input wire logic ques_cal_summary, // Bit 8
  input wire logic irq // Interrupt
);
  longint gap_r;
  always_ff @(posedge sys_clk) begin
    if (!nrst || !error_rate_test_active || error_rate_test_clk) gap_r <= 0;
    else gap_r <= gap_r + 1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("rdata set without read");
  AST_QUES_ERT: assert property (rd && addr == QSG_QUES_COND |=> rdata[12] == $past(ques_ert_summary))
    else $error("bit 12 differs from summary");
  AST_QUES_CAL: assert property (rd && addr == QSG_QUES_COND |=> rdata[8] == $past(ques_cal_summary))
    else $error("bit 8 differs from summary");
  AST_COND_LIVE: assert property (rd && addr == QSG_ERT_COND && $stable(ert_cond_ext)
    |=> rdata[W-1:1] == $past(ert_cond_ext[W-1:1]))
    else $error("cond read not live");
  AST_CAL_FAIL: assert property (cal_fail_dc_freq_mod [*4] ##0 (rd && addr == QSG_CAL_COND) |=> rdata[0])
    else $error("cal fail bit missing");
  AST_NOCLK: assert property (rd && addr == QSG_ERT_COND && gap_r > NOCLK_CYCLES + 4 |=> rdata[0])
    else $error("missing clock bit not set");
  AST_PRESET: assert property (wr && addr == QSG_PRESET |=> !ques_ert_summary && !ques_cal_summary)
    else $error("summary after preset");
  AST_ERT_EN0: assert property (wr && addr == QSG_ERT_ENABLE && wdata == 16'h0000 |=> !ques_ert_summary)
    else $error("ert summary with no enable");
  AST_CAL_EN0: assert property (wr && addr == QSG_CAL_ENABLE && wdata == 16'h0000 |=> !ques_cal_summary)
    else $error("cal summary with no enable");
  COV_EVT: cover property (rd && addr == QSG_ERT_EVENT ##1 rdata != 16'h0000);
  COV_PRE: cover property (wr && addr == QSG_PRESET);
  COV_IRQ: cover property (irq);
endmodule : qsg_status_checker
bind qsg_status qsg_status_checker #(.W(W), .NOCLK_CYCLES(NOCLK_CYCLES)) u_chk (.sys_clk, .nrst,
  .addr, .wdata, .wr, .rd, .rdata, .error_rate_test_active, .error_rate_test_clk,
  .cal_fail_dc_freq_mod, .cal_fail_dc_phase_mod, .ert_cond_ext, .cal_cond_ext,
  .ques_ert_summary, .ques_cal_summary, .irq);

/* verif/tb.sv */
// Testbench: registers, transitions, pins, preset and interrupt
`timescale 1ns/1ns
module tb;
  logic sys_clk = 0, nrst = 0, wr = 0, rd = 0, rd_d = 0;
  logic act = 0, tclk = 0, ffm = 0, fpm = 0, qe, qc, irq, sb;
  logic [3:0] addr = 4'h0, b;
  logic [15:0] wdata = 16'h0000, rdata, ec = 16'h0000, cc = 16'h0000;
  logic [15:0] rf, ff, en, ev, pv, v;
  logic [31:0] expq[$];
  int miscompares = 0, total_checks = 0;
  integer seed = 32'h88325084;
  qsg_status #(.NOCLK_CYCLES(20)) dut (.sys_clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
    .error_rate_test_active(act), .error_rate_test_clk(tclk), .cal_fail_dc_freq_mod(ffm),
    .cal_fail_dc_phase_mod(fpm), .ert_cond_ext(ec), .cal_cond_ext(cc),
    .ques_ert_summary(qe), .ques_cal_summary(qc), .irq);
  always #10 sys_clk = ~sys_clk;
  task automatic chk(input logic [15:0] got, exp, msk);
    total_checks++;
    if ((got & msk) !== (exp & msk)) begin
      miscompares++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // Outputs looked at mid-cycle, once settled; bit 2 irq, bit 1 ert, bit 0 cal
  task automatic chk_out(input logic [15:0] e, m);
    @(negedge sys_clk);
    chk({13'h0, irq, qe, qc}, e, m);
    @(posedge sys_clk);
  endtask : chk_out
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    rd <= 1'b0;
    @(posedge sys_clk);
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [15:0] e, m = 16'hFFFF);
    expq.push_back({m, e});
    addr <= a;
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge sys_clk);
  endtask : rreg
  task automatic idle(input int n = 1);
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (n) @(posedge sys_clk);
  endtask : idle
  task automatic defaults;
    for (int g = 0; g < 2; g++) begin
      rreg(g ? 4'h8 : 4'h3, 16'hFFFF);
      rreg(g ? 4'h9 : 4'h4, 16'h0000);
      rreg(g ? 4'h7 : 4'h2, 16'h0000);
    end
    idle(2);
  endtask : defaults
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : print_verdict
  // ----------------------------------------
  // Read data monitor
  // ----------------------------------------
  always @(posedge sys_clk) rd_d <= rd;
  always @(negedge sys_clk) begin
    if (rd_d && expq.size() > 0) begin
      chk(rdata, expq[0][15:0], expq[0][31:16]);
      void'(expq.pop_front());
    end
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    miscompares++;
    print_verdict();
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    nrst <= 1'b1;
    @(posedge sys_clk);
    defaults();
    wreg(4'hE, 16'h1234);
    rreg(4'hE, 16'h0000);
    rreg(4'hF, 16'h0000);
    rreg(4'hC, 16'h0000);
    rreg(4'hD, 16'h0000);
    $display("test reset done");
    for (int g = 0; g < 2; g++) begin
      for (int o = 2; o < 5; o++) begin
        b = (g ? 4'h5 : 4'h0) + o[3:0];
        v = $random(seed);
        wreg(b, v);
        rreg(b, v);
      end
      wreg(g ? 4'h5 : 4'h0, 16'hFFFF);
      rreg(g ? 4'h5 : 4'h0, 16'h0000, 16'hFFFE);
    end
    $display("test readback done");
    for (int g = 0; g < 2; g++) begin
      b = g ? 4'h5 : 4'h0;
      rf = $random(seed) & 16'hFFFE;
      ff = $random(seed) & 16'hFFFE;
      en = $random(seed) | 16'h00FE;
      wreg(b + 4'h3, rf);
      wreg(b + 4'h4, ff);
      wreg(b + 4'h2, en);
      wreg(4'hD, 16'h0003);
      wreg(4'hC, 16'h0003);
      rreg(b + 4'h1, 16'h0000, 16'hFFFE);
      ev = 16'h0000;
      pv = 16'h0000;
      for (int k = 0; k < 6; k++) begin
        v = $random(seed) & 16'hFFFE;
        if (g == 0) ec <= v;
        else cc <= v;
        idle(1);
        ev = ev | (v & ~pv & rf) | (pv & ~v & ff);
        pv = v;
      end
      idle(3);
      sb = |(ev & en & 16'hFFFE);
      chk_out(sb ? (g ? 16'h0001 : 16'h0002) : 16'h0000, g ? 16'h0001 : 16'h0002);
      rreg(4'hA, sb ? (g ? 16'h0100 : 16'h1000) : 16'h0000, 16'h1100);
      rreg(b, pv, 16'hFFFE);
      rreg(b, pv, 16'hFFFE);
      rreg(b + 4'h1, ev, 16'hFFFE);
      rreg(b + 4'h1, 16'h0000, 16'hFFFE);
      idle(1);
      chk_out(16'h0000, g ? 16'h0001 : 16'h0002);
      chk_out({13'h0, ev != 0, 2'b00}, 16'h0004);
      rreg(4'hC, (ev != 0) ? (g ? 16'h0002 : 16'h0001) : 16'h0000, 16'h0003);
      wreg(4'hD, 16'h0000);
      idle(1);
      chk_out(16'h0000, 16'h0004);
      wreg(4'hD, 16'h0003);
      wreg(4'hC, 16'h0003);
      idle(1);
      chk_out(16'h0000, 16'h0004);
      $display("test group %0d done", g);
    end
    ffm <= 1'b1;
    idle(4);
    rreg(4'h5, 16'h0001, 16'h0001);
    ffm <= 1'b0;
    fpm <= 1'b1;
    idle(4);
    rreg(4'h5, 16'h0001, 16'h0001);
    fpm <= 1'b0;
    idle(4);
    rreg(4'h5, 16'h0000, 16'h0001);
    act <= 1'b1;
    repeat (20) begin
      tclk <= ~tclk;
      idle(2);
    end
    rreg(4'h0, 16'h0000, 16'h0001);
    tclk <= 1'b0;
    idle(30);
    rreg(4'h0, 16'h0001, 16'h0001);
    act <= 1'b0;
    idle(4);
    rreg(4'h0, 16'h0000, 16'h0001);
    $display("test pins done");
    wreg(4'hB, $random(seed));
    idle(1);
    chk_out(16'h0000, 16'h0003);
    defaults();
    $display("test preset done");
    print_verdict();
  end
endmodule : tb
